// *** hdl/ctd_pkg.sv ***
// Shared constants for the core instruction timing and decode block.
package ctd_pkg;
	// Instruction cycle phases.
	localparam int Q_PER_CYCLE = 4;
	localparam logic [1:0] Q_FETCH = 2'h0;
	localparam logic [1:0] Q_READ = 2'h1;
	localparam logic [1:0] Q_CALC = 2'h2;
	localparam logic [1:0] Q_LAST = 2'h3;
	// Widths.
	localparam int INSN_W = 14;
	localparam int FILE_W = 7;
	localparam int DATA_W = 8;
	localparam int PC_W = 15;
	// Field positions inside an instruction word.
	localparam int CLS_HI = 13;
	localparam int CLS_LO = 12;
	localparam int OP_HI = 11;
	localparam int OP_LO = 8;
	localparam int BOP_HI = 11;
	localparam int BOP_LO = 10;
	localparam int DEST_POS = 7;
	localparam int FILE_HI = 6;
	localparam int BIT_HI = 9;
	localparam int BIT_LO = 7;
	localparam int JUMP_POS = 11;
	localparam int LIT_HI = 10;
	localparam int REL_HI = 8;
	localparam int PNUM_POS = 2;
	localparam int MODE_HI = 1;
	// Instruction classes.
	typedef enum logic [1:0]
	{
		CLS_BYTE = 2'b00,
		CLS_BIT = 2'b01,
		CLS_CTRL = 2'b10,
		CLS_LIT = 2'b11
	} ctd_class_e;
	// Byte oriented operations.
	localparam logic [3:0] OP_MOVF = 4'h0;
	localparam logic [3:0] OP_MOVWF = 4'h1;
	localparam logic [3:0] OP_CLRF = 4'h2;
	localparam logic [3:0] OP_ADDWF = 4'h3;
	localparam logic [3:0] OP_ANDWF = 4'h4;
	localparam logic [3:0] OP_IORWF = 4'h5;
	localparam logic [3:0] OP_XORWF = 4'h6;
	localparam logic [3:0] OP_INCF = 4'h7;
	localparam logic [3:0] OP_DECF = 4'h8;
	localparam logic [3:0] OP_COMF = 4'h9;
	localparam logic [3:0] OP_DEC_SKIP_ZERO = 4'hA;
	localparam logic [3:0] OP_INC_SKIP_ZERO = 4'hB;
	// Bit oriented operations.
	localparam logic [1:0] BOP_CLEAR = 2'h0;
	localparam logic [1:0] BOP_SET = 2'h1;
	localparam logic [1:0] BOP_SKIP_CLEAR = 2'h2;
	localparam logic [1:0] BOP_SKIP_SET = 2'h3;
	// Literal and misc operations.
	localparam logic [3:0] OP_MOVLW = 4'h0;
	localparam logic [3:0] OP_RET_LIT = 4'h1;
	localparam logic [3:0] OP_RET = 4'h2;
	localparam logic [3:0] OP_RET_IRQ = 4'h3;
	localparam logic [3:0] OP_CALL_WREG = 4'h4;
	localparam logic [3:0] OP_BRANCH_WREG = 4'h5;
	localparam logic [3:0] OP_BRANCH_REL = 4'h6;
	localparam logic [3:0] OP_MOVE_IND_TO_W = 4'h7;
	localparam logic [3:0] OP_MOVE_W_TO_IND = 4'h8;
	// Addresses of the two indirect access ports.
	localparam logic [6:0] IND_PORT0 = 7'h00;
	localparam logic [6:0] IND_PORT1 = 7'h01;
	// Reset values.
	localparam logic [14:0] RESET_PC = 15'h0000;
	localparam logic [7:0] RESET_W = 8'h00;
	localparam logic [13:0] RESET_INSN = 14'h3FFF;
endpackage

// *** hdl/ctd_field_decode.sv ***
// Splits a 14-bit instruction word into its operand fields.
`timescale 1ns/100ps
module ctd_field_decode
(
	// Instruction word.
	input wire logic [13:0] insn_in,
	// Class and operation.
	output logic [1:0] cls_out,
	output logic [3:0] op_out,
	output logic [1:0] bop_out,
	// Operands.
	output logic [6:0] file_adr_out,
	output logic dest_file_out,
	output logic [2:0] bit_pos_out,
	output logic [10:0] lit_out,
	output logic ptr_num_out,
	output logic [1:0] ptr_mode_out,
	// Timing and access classes.
	output logic uses_file_out,
	output logic ptr_step_out,
	output logic indirect_out,
	output logic is_skip_out,
	output logic two_cycle_out
);
	wire is_byte;
	wire is_bit;
	wire is_ctrl;
	wire is_lit;
	wire lit_ind;
	wire lit_two;

	assign cls_out = insn_in[ctd_pkg::CLS_HI:ctd_pkg::CLS_LO];
	assign op_out = insn_in[ctd_pkg::OP_HI:ctd_pkg::OP_LO];
	assign bop_out = insn_in[ctd_pkg::BOP_HI:ctd_pkg::BOP_LO];
	assign is_byte = cls_out == ctd_pkg::CLS_BYTE;
	assign is_bit = cls_out == ctd_pkg::CLS_BIT;
	assign is_ctrl = cls_out == ctd_pkg::CLS_CTRL;
	assign is_lit = cls_out == ctd_pkg::CLS_LIT;
	assign lit_ind = is_lit && (op_out == ctd_pkg::OP_MOVE_IND_TO_W
		|| op_out == ctd_pkg::OP_MOVE_W_TO_IND);
	// Bits outside a field are never looked at.
	assign file_adr_out = lit_ind
		? (insn_in[ctd_pkg::PNUM_POS] ? ctd_pkg::IND_PORT1
		: ctd_pkg::IND_PORT0)
		: insn_in[ctd_pkg::FILE_HI:0];
	assign dest_file_out = is_byte && (insn_in[ctd_pkg::DEST_POS]
		|| op_out == ctd_pkg::OP_MOVWF
		|| op_out == ctd_pkg::OP_CLRF);
	assign bit_pos_out = insn_in[ctd_pkg::BIT_HI:ctd_pkg::BIT_LO];
	assign lit_out = insn_in[ctd_pkg::LIT_HI:0];
	assign ptr_num_out = lit_ind ? insn_in[ctd_pkg::PNUM_POS]
		: file_adr_out == ctd_pkg::IND_PORT1;
	assign ptr_mode_out = lit_ind ? insn_in[ctd_pkg::MODE_HI:0]
		: 2'h0;
	assign ptr_step_out = lit_ind;
	assign uses_file_out = is_byte || is_bit || lit_ind;
	assign indirect_out = uses_file_out
		&& (file_adr_out == ctd_pkg::IND_PORT0
		|| file_adr_out == ctd_pkg::IND_PORT1);
	assign is_skip_out = (is_bit && bop_out[1]) || (is_byte
		&& (op_out == ctd_pkg::OP_DEC_SKIP_ZERO
		|| op_out == ctd_pkg::OP_INC_SKIP_ZERO));
	assign lit_two = is_lit && (op_out == ctd_pkg::OP_RET_LIT
		|| op_out == ctd_pkg::OP_RET || op_out == ctd_pkg::OP_RET_IRQ
		|| op_out == ctd_pkg::OP_CALL_WREG
		|| op_out == ctd_pkg::OP_BRANCH_WREG
		|| op_out == ctd_pkg::OP_BRANCH_REL);
	assign two_cycle_out = is_ctrl || lit_two;
endmodule

// *** hdl/ctd_core_timing.sv ***
// Instruction fetch, decode, timing and read-modify-write core.
`timescale 1ns/100ps
module ctd_core_timing
#(
	parameter int STACK_DEPTH = 16
)
(
	// Clock and reset.
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	// Program memory.
	output logic [14:0] PM_ADDR_OUT,
	input wire logic [13:0] PM_DATA_IN,
	// Register file.
	output logic [6:0] RF_ADDR_OUT,
	output logic RF_RD_OUT,
	input wire logic [7:0] RF_RDATA_IN,
	output logic RF_WR_OUT,
	output logic [7:0] RF_WDATA_OUT,
	// Indirect pointers.
	input wire logic [1:0] PTR_IN_PROG_IN,
	output logic PTR_NUM_OUT,
	output logic [1:0] PTR_MODE_OUT,
	output logic PTR_STEP_OUT,
	// Status.
	output logic [1:0] QPHASE_OUT,
	output logic INSN_START_OUT,
	output logic STALL_OUT,
	output logic [7:0] W_OUT
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	logic [1:0] q;
	logic [1:0] extra;
	logic [13:0] ir;
	logic [14:0] pc;
	logic [7:0] wreg;
	logic [7:0] res;
	logic [SP_W-1:0] sp;
	logic [14:0] stack [STACK_DEPTH];
	logic [7:0] alu;
	logic alu_wr_w;
	logic alu_wr_f;

	wire [1:0] cls;
	wire [3:0] op;
	wire [1:0] bop;
	wire [6:0] file_adr;
	wire dest_file;
	wire [2:0] bit_pos;
	wire [10:0] lit;
	wire ptr_num;
	wire [1:0] ptr_mode;
	wire uses_file;
	wire ptr_step;
	wire indirect;
	wire is_skip;
	wire two_cycle;
	wire exec;
	wire last_q;
	wire skip_taken;
	wire prog_extra;
	wire [1:0] next_extra;
	wire [7:0] bit_mask;
	wire [14:0] pc_inc;
	wire [14:0] pc_rel;
	wire [14:0] next_pc;
	wire is_lit;
	wire is_ctrl;
	wire do_call;
	wire do_ret;
	wire [SP_W-1:0] sp_pop;

	// Field split of the current word.
	ctd_field_decode u_decode
	(
		.insn_in(ir),
		.cls_out(cls),
		.op_out(op),
		.bop_out(bop),
		.file_adr_out(file_adr),
		.dest_file_out(dest_file),
		.bit_pos_out(bit_pos),
		.lit_out(lit),
		.ptr_num_out(ptr_num),
		.ptr_mode_out(ptr_mode),
		.uses_file_out(uses_file),
		.ptr_step_out(ptr_step),
		.indirect_out(indirect),
		.is_skip_out(is_skip),
		.two_cycle_out(two_cycle)
	);

	assign exec = extra == 2'h0;
	assign last_q = q == ctd_pkg::Q_LAST;
	assign is_lit = cls == ctd_pkg::CLS_LIT;
	assign is_ctrl = cls == ctd_pkg::CLS_CTRL;
	assign bit_mask = 8'h01 << bit_pos;
	assign skip_taken = is_skip && ((cls == ctd_pkg::CLS_BIT)
		? (bop[0] == |(res & bit_mask)) : res == 8'h00);
	assign prog_extra = indirect && PTR_IN_PROG_IN[ptr_num];
	// Skips count two when taken, and a pointer into program memory adds one
	// more; the rest of the two-cycle class always counts two.
	assign next_extra = {1'b0, two_cycle || skip_taken}
		+ {1'b0, prog_extra};
	assign pc_inc = pc + 15'h0001;
	assign pc_rel = pc_inc + {{6{lit[ctd_pkg::REL_HI]}},
		lit[ctd_pkg::REL_HI:0]};
	assign do_call = (is_ctrl && !ir[ctd_pkg::JUMP_POS])
		|| (is_lit && op == ctd_pkg::OP_CALL_WREG);
	assign do_ret = is_lit && (op == ctd_pkg::OP_RET_LIT
		|| op == ctd_pkg::OP_RET || op == ctd_pkg::OP_RET_IRQ);
	assign sp_pop = sp - {{(SP_W-1){1'b0}}, 1'b1};
	assign next_pc = do_ret ? stack[sp_pop]
		: is_ctrl ? {pc[14:11], lit}
		: (is_lit && op == ctd_pkg::OP_CALL_WREG)
		? {pc[14:8], wreg}
		: (is_lit && op == ctd_pkg::OP_BRANCH_WREG)
		? pc_inc + {7'h00, wreg}
		: (is_lit && op == ctd_pkg::OP_BRANCH_REL) ? pc_rel
		: skip_taken ? pc_inc + 15'h0001 : pc_inc;

	// Result of the modify step and where it goes.
	always_comb
	begin
		alu = RF_RDATA_IN;
		alu_wr_w = 1'b0;
		alu_wr_f = 1'b0;
		if (cls == ctd_pkg::CLS_BYTE)
		begin
			alu_wr_w = !dest_file;
			alu_wr_f = dest_file;
			case (op)
				ctd_pkg::OP_MOVF: alu = RF_RDATA_IN;
				ctd_pkg::OP_MOVWF: alu = wreg;
				ctd_pkg::OP_CLRF: alu = 8'h00;
				ctd_pkg::OP_ADDWF: alu = RF_RDATA_IN + wreg;
				ctd_pkg::OP_ANDWF: alu = RF_RDATA_IN & wreg;
				ctd_pkg::OP_IORWF: alu = RF_RDATA_IN | wreg;
				ctd_pkg::OP_XORWF: alu = RF_RDATA_IN ^ wreg;
				ctd_pkg::OP_INCF: alu = RF_RDATA_IN + 8'h01;
				ctd_pkg::OP_DECF: alu = RF_RDATA_IN - 8'h01;
				ctd_pkg::OP_COMF: alu = ~RF_RDATA_IN;
				ctd_pkg::OP_DEC_SKIP_ZERO: alu = RF_RDATA_IN - 8'h01;
				ctd_pkg::OP_INC_SKIP_ZERO: alu = RF_RDATA_IN + 8'h01;
				default:
				begin
					alu_wr_w = 1'b0;
					alu_wr_f = 1'b0;
				end
			endcase
		end
		else if (cls == ctd_pkg::CLS_BIT)
		begin
			alu_wr_f = !bop[1];
			// Bit tests keep the word as read so that the skip sees it.
			alu = bop[1] ? RF_RDATA_IN
				: bop[0] ? (RF_RDATA_IN | bit_mask)
				: (RF_RDATA_IN & ~bit_mask);
		end
		else if (is_lit && op == ctd_pkg::OP_MOVE_IND_TO_W)
		begin
			alu_wr_w = 1'b1;
		end
		else if (is_lit && op == ctd_pkg::OP_MOVE_W_TO_IND)
		begin
			alu = wreg;
			alu_wr_f = 1'b1;
		end
	end

	// Four oscillator clocks per instruction cycle.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			q <= ctd_pkg::Q_FETCH;
		else
			q <= q + 2'h1;
	end

	// Fetch at the first phase of a new instruction.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			ir <= ctd_pkg::RESET_INSN;
		else if (exec && q == ctd_pkg::Q_FETCH)
			ir <= PM_DATA_IN;
	end

	// Cycles still owed by the current instruction.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			extra <= 2'h0;
		else if (last_q && exec)
			extra <= next_extra;
		else if (last_q)
			extra <= extra - 2'h1;
	end

	// Modified value, held for the write phase.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			res <= 8'h00;
		else if (exec && q == ctd_pkg::Q_CALC)
			res <= alu;
	end

	// Working register update.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			wreg <= ctd_pkg::RESET_W;
		else if (exec && last_q && alu_wr_w)
			wreg <= res;
		else if (exec && last_q && is_lit
			&& (op == ctd_pkg::OP_MOVLW || op == ctd_pkg::OP_RET_LIT))
			wreg <= lit[7:0];
	end

	// Program counter and return stack.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			pc <= ctd_pkg::RESET_PC;
			sp <= '0;
		end
		else if (exec && last_q)
		begin
			pc <= next_pc;
			if (do_call)
				sp <= sp + {{(SP_W-1){1'b0}}, 1'b1};
			else if (do_ret)
				sp <= sp_pop;
		end
	end

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (exec && last_q && do_call)
			stack[sp] <= pc_inc;
	end

	// Every file operand is read before it is written.
	assign RF_RD_OUT = exec && uses_file && q == ctd_pkg::Q_READ;
	assign RF_WR_OUT = exec && alu_wr_f && last_q;
	assign RF_WDATA_OUT = res;
	assign RF_ADDR_OUT = file_adr;
	assign PM_ADDR_OUT = pc;
	assign PTR_NUM_OUT = ptr_num;
	assign PTR_MODE_OUT = ptr_mode;
	assign PTR_STEP_OUT = exec && ptr_step && last_q;
	assign QPHASE_OUT = q;
	assign INSN_START_OUT = exec && q == ctd_pkg::Q_FETCH;
	assign STALL_OUT = !exec;
	assign W_OUT = wreg;
endmodule

// *** verif/ctd_core_timing_monitor.sv ***
// Concurrent checks on the ports of the timing and decode core.
`timescale 1ns/100ps
module ctd_core_timing_monitor
(
	// Clock and reset.
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	// Watched outputs.
	input wire logic [14:0] PM_ADDR_OUT,
	input wire logic [6:0] RF_ADDR_OUT,
	input wire logic RF_RD_OUT,
	input wire logic RF_WR_OUT,
	input wire logic PTR_STEP_OUT,
	input wire logic [1:0] QPHASE_OUT,
	input wire logic INSN_START_OUT,
	input wire logic STALL_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	chk_phase_step: assert property (
		1'b1 |=> QPHASE_OUT == $past(QPHASE_OUT) + 2'h1)
		else $error("phase counter did not advance by one");
	chk_fetch_gap: assert property (
		INSN_START_OUT |=> !INSN_START_OUT [*3])
		else $error("fetches closer than four clocks");
	chk_start_q0: assert property (
		INSN_START_OUT |-> QPHASE_OUT == 2'h0 && !STALL_OUT)
		else $error("instruction start outside first phase");
	chk_read_q1: assert property (
		RF_RD_OUT |-> QPHASE_OUT == 2'h1 && !STALL_OUT)
		else $error("file read outside second phase");
	chk_write_after_read: assert property (
		RF_WR_OUT |-> QPHASE_OUT == 2'h3 && $past(RF_RD_OUT, 2))
		else $error("file write without the read before it");
	chk_stall_len: assert property (
		$rose(STALL_OUT) |-> QPHASE_OUT == 2'h0 ##0 STALL_OUT [*4])
		else $error("extra cycle not four whole clocks");
	chk_no_access_stall: assert property (
		STALL_OUT |-> !RF_RD_OUT && !RF_WR_OUT)
		else $error("file access during extra cycle");
	chk_step_q3: assert property (
		PTR_STEP_OUT |-> QPHASE_OUT == 2'h3 ##1 !PTR_STEP_OUT)
		else $error("pointer step not a last phase pulse");
	chk_pm_hold: assert property (
		QPHASE_OUT != 2'h0 |-> $stable(PM_ADDR_OUT))
		else $error("program address moved inside a cycle");
	chk_file_addr_hold: assert property (
		QPHASE_OUT[1] |-> $stable(RF_ADDR_OUT))
		else $error("file address moved during access");
endmodule
bind ctd_core_timing ctd_core_timing_monitor ctd_core_timing_monitor_i
(
	.SYS_CLK_IN, .RSTN_IN, .PM_ADDR_OUT, .RF_ADDR_OUT, .RF_RD_OUT,
	.RF_WR_OUT, .PTR_STEP_OUT, .QPHASE_OUT, .INSN_START_OUT, .STALL_OUT
);

// *** verif/ctd_mem_model.sv ***
// Program memory and register file that sit around the timing core.
`timescale 1ns/100ps
module ctd_mem_model
(
	// Clock.
	input wire logic clk_in,
	// Program memory.
	input wire logic [14:0] pm_addr_in,
	output logic [13:0] pm_data_out,
	// Register file.
	input wire logic [6:0] rf_addr_in,
	input wire logic rf_rd_in,
	output logic [7:0] rf_rdata_out,
	input wire logic rf_wr_in,
	input wire logic [7:0] rf_wdata_in
);
	logic [13:0] pm [64];
	logic [7:0] rf [128];
	logic rd_q = 1'b0;
	logic tog = 1'b0;
	// Whole words come out at once; past the image a no-op.
	assign pm_data_out = (pm_addr_in < 15'h0040) ? pm[pm_addr_in[5:0]] : 14'h3FFF;
	// Data only in the clock after the strobe, a toggling pattern else.
	assign rf_rdata_out = rd_q ? rf[rf_addr_in] : {8{tog}};
	always @(posedge clk_in)
	begin
		rd_q <= rf_rd_in;
		tog <= ~tog;
		if (rf_wr_in)
			rf[rf_addr_in] <= rf_wdata_in;
	end
endmodule

// *** verif/ctd_core_timing_tb.sv ***
// Self-checking bench for the timing and decode core.
`timescale 1ns/100ps
module ctd_core_timing_tb;
	typedef struct
	{
		logic [14:0] a;
		logic [13:0] i;
		int cyc;
		logic [7:0] w;
	} ctd_row_s;
	logic SYS_CLK_IN = 1'b0;
	logic RSTN_IN = 1'b0;
	logic [1:0] PTR_IN_PROG_IN = 2'b10;
	logic [14:0] PM_ADDR_OUT;
	logic [13:0] PM_DATA_IN;
	logic [6:0] RF_ADDR_OUT;
	logic RF_RD_OUT, RF_WR_OUT, PTR_NUM_OUT, PTR_STEP_OUT;
	logic [7:0] RF_RDATA_IN, RF_WDATA_OUT, W_OUT;
	logic [1:0] PTR_MODE_OUT, QPHASE_OUT;
	logic INSN_START_OUT, STALL_OUT;
	int n_mismatch = 0;
	int num_checks = 0;
	int n;
	// Unused instruction bits are zero here, except bit 7 of the MOVWF and CLRF words.
	ctd_row_s rows [36] = '{
		'{15'h00, 14'h3005, 1, 8'h05}, '{15'h01, 14'h0390, 1, 8'h05},
		'{15'h02, 14'h0310, 1, 8'h2C}, '{15'h03, 14'h2020, 2, 8'h2C},
		'{15'h20, 14'h312A, 2, 8'h2A}, '{15'h04, 14'h2805, 2, 8'h2A},
		'{15'h05, 14'h3601, 2, 8'h2A}, '{15'h07, 14'h3003, 1, 8'h03},
		'{15'h08, 14'h3500, 2, 8'h03}, '{15'h0C, 14'h3030, 1, 8'h30},
		'{15'h0D, 14'h3400, 2, 8'h30}, '{15'h30, 14'h3300, 2, 8'h30},
		'{15'h0E, 14'h3802, 1, 8'h30}, '{15'h0F, 14'h3806, 2, 8'h30},
		'{15'h10, 14'h0180, 1, 8'h30}, '{15'h11, 14'h0A92, 1, 8'h30},
		'{15'h12, 14'h1794, 1, 8'h30}, '{15'h13, 14'h0B93, 2, 8'h30},
		'{15'h15, 14'h1C16, 2, 8'h30}, '{15'h17, 14'h1816, 1, 8'h30},
		'{15'h18, 14'h1016, 1, 8'h30}, '{15'h19, 14'h1C16, 1, 8'h30},
		'{15'h1A, 14'h1816, 2, 8'h30}, '{15'h1C, 14'h0016, 1, 8'h40},
		'{15'h1D, 14'h0610, 1, 8'h67}, '{15'h1E, 14'h0412, 1, 8'h04},
		'{15'h1F, 14'h2821, 2, 8'h04}, '{15'h21, 14'h0510, 1, 8'h27},
		'{15'h22, 14'h0910, 1, 8'hD8}, '{15'h23, 14'h0712, 1, 8'h05},
		'{15'h24, 14'h0810, 1, 8'h26}, '{15'h25, 14'h0295, 1, 8'h26},
		'{15'h26, 14'h3701, 1, 8'h30}, '{15'h27, 14'h202A, 2, 8'h30},
		'{15'h2A, 14'h3200, 2, 8'h30}, '{15'h28, 14'h3007, 1, 8'h07}};
	always #50 SYS_CLK_IN = ~SYS_CLK_IN;
	ctd_core_timing ctd_core_timing_i
	(
		.SYS_CLK_IN, .RSTN_IN, .PM_ADDR_OUT, .PM_DATA_IN, .RF_ADDR_OUT,
		.RF_RD_OUT, .RF_RDATA_IN, .RF_WR_OUT, .RF_WDATA_OUT,
		.PTR_IN_PROG_IN, .PTR_NUM_OUT, .PTR_MODE_OUT, .PTR_STEP_OUT,
		.QPHASE_OUT, .INSN_START_OUT, .STALL_OUT, .W_OUT
	);
	ctd_mem_model ctd_mem_model_i
	(
		.clk_in(SYS_CLK_IN), .pm_addr_in(PM_ADDR_OUT),
		.pm_data_out(PM_DATA_IN), .rf_addr_in(RF_ADDR_OUT),
		.rf_rd_in(RF_RD_OUT), .rf_rdata_out(RF_RDATA_IN),
		.rf_wr_in(RF_WR_OUT), .rf_wdata_in(RF_WDATA_OUT)
	);
	task automatic chk_val(input logic [15:0] got, exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic to_start();
		n = 0;
		do
		begin
			@(negedge SYS_CLK_IN);
			n++;
		end
		while (INSN_START_OUT !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			n_mismatch++;
			close_out();
		end
	endtask
	initial
	begin
		for (int k = 0; k < 64; k++)
			ctd_mem_model_i.pm[k] = 14'h3FFF;
		for (int k = 0; k < 128; k++)
			ctd_mem_model_i.rf[k] = 8'h00;
		foreach (rows[k])
			ctd_mem_model_i.pm[rows[k].a[5:0]] = rows[k].i;
		ctd_mem_model_i.rf[16] = 8'h22;
		ctd_mem_model_i.rf[18] = 8'h05;
		ctd_mem_model_i.rf[19] = 8'hFF;
		ctd_mem_model_i.rf[20] = 8'h01;
		ctd_mem_model_i.rf[21] = 8'h5A;
		ctd_mem_model_i.rf[22] = 8'h41;
		// Words behind a taken skip would load a marker into W.
		ctd_mem_model_i.pm[20] = 14'h30EE;
		ctd_mem_model_i.pm[22] = 14'h30EE;
		ctd_mem_model_i.pm[27] = 14'h30EE;
		repeat (12) @(negedge SYS_CLK_IN);
		RSTN_IN = 1'b1;
		foreach (rows[k])
		begin
			chk_val({1'b0, PM_ADDR_OUT}, {1'b0, rows[k].a}, "fetch");
			to_start();
			chk_val(16'(n), 16'(4 * rows[k].cyc), "clocks");
			chk_val({8'h00, W_OUT}, {8'h00, rows[k].w}, "wreg");
			if (rows[k].a[14:1] == 14'h0007)
				chk_val({13'h0, PTR_NUM_OUT, PTR_MODE_OUT},
					{13'h0, rows[k].a[0], 2'h2}, "pointer");
		end
		chk_val({8'h00, ctd_mem_model_i.rf[16]}, 16'h0027, "sum");
		chk_val({8'h00, ctd_mem_model_i.rf[18]}, 16'h0004, "dec");
		chk_val({8'h00, ctd_mem_model_i.rf[19]}, 16'h0000, "inc");
		chk_val({8'h00, ctd_mem_model_i.rf[20]}, 16'h0081, "bit");
		chk_val({8'h00, ctd_mem_model_i.rf[21]}, 16'h0000, "clr");
		chk_val({8'h00, ctd_mem_model_i.rf[22]}, 16'h0040, "bclr");
		$display("program rows done");
		@(negedge SYS_CLK_IN);
		RSTN_IN = 1'b0;
		#10;
		chk_val({1'b0, PM_ADDR_OUT}, 16'h0000, "reset pc");
		chk_val({4'h0, QPHASE_OUT, INSN_START_OUT, STALL_OUT, W_OUT},
			16'h0200, "reset state");
		repeat (3) @(negedge SYS_CLK_IN);
		RSTN_IN = 1'b1;
		to_start();
		chk_val(16'(n), 16'h0004, "restart clocks");
		chk_val({8'h00, W_OUT}, 16'h0005, "restart wreg");
		$display("mid-run reset done");
		close_out();
	end
endmodule
